// File: core/tfa_top.v
// What this block does
// - Format bit picks two's complement or offset.
// - Bit 6 flags alignment after chip reset.
// - Bit 5 flags alignment after frame reset.
// - Bit 4 acknowledges serial-port requested alignment.
// - Pointers set apart by three-bit offset.
// - Buffer holds eight entries, ideally half full.
// - Level field: one bit per valid entry.
// - Level is wrapping thermometer, read to write.
// - Shaping gain code/16 scales I and Q.
// - First interpolation gain code/16 scales both.
`timescale 1ns/1ps
`default_nettype none
module tfa_top #(
  parameter W     = 12,
  parameter DEPTH = 8
) (
  // Clock, reset, enable
  input  wire         clk_sys,
  input  wire         resetn,
  input  wire         ce,
  // Link side, all asynchronous to clk_sys
  input  wire         interface_clock_pin,
  input  wire         frame_in,
  input  wire [W-1:0] tx_i,
  input  wire [W-1:0] tx_q,
  // Format select
  input  wire         sample_format_select,
  // Register access
  input  wire         reg_wr,
  input  wire [7:0]   reg_addr,
  input  wire [7:0]   reg_wdata,
  output reg  [7:0]   reg_rdata,
  // Transmit path outputs
  output wire [W-1:0] shaped_i,
  output wire [W-1:0] shaped_q,
  output wire [W-1:0] interp_i,
  output wire [W-1:0] interp_q,
  output reg  [W-1:0] rd_i_q,
  output reg  [W-1:0] rd_q_q
);
`include "tfa_defs.vh"
  // Two-stage synchronisers for the link pins.
  reg  [2:0]     clk_s_q;
  reg  [1:0]     frm_s_q;
  reg  [W-1:0]   di_s1_q;
  reg  [W-1:0]   di_s2_q;
  reg  [W-1:0]   dq_s1_q;
  reg  [W-1:0]   dq_s2_q;
  reg            frm_d_q;
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      clk_s_q <= 3'h0;
      frm_s_q <= 2'h0;
      frm_d_q <= 1'b0;
      di_s1_q <= {W{1'b0}};
      di_s2_q <= {W{1'b0}};
      dq_s1_q <= {W{1'b0}};
      dq_s2_q <= {W{1'b0}};
    end else if (ce) begin
      clk_s_q <= {clk_s_q[1:0], interface_clock_pin};
      frm_s_q <= {frm_s_q[0], frame_in};
      frm_d_q <= frm_s_q[1];
      di_s1_q <= tx_i;
      di_s2_q <= di_s1_q;
      dq_s1_q <= tx_q;
      dq_s2_q <= dq_s1_q;
    end
  end
  wire wr_tick = clk_s_q[1] & ~clk_s_q[2];
  wire frame_rise = frm_s_q[1] & ~frm_d_q;

  // Registers.
  reg  [2:0]     ofs_q;
  reg            req_q;
  reg            init_q;
  reg            framed_q;
  reg            ack_q;
  reg  [4:0]     shg_q;
  reg  [4:0]     i1g_q;
  reg            boot_q;
  reg            align_busy_q;
  // Request edge: a held request realigns once, not every cycle.
  wire req_new = req_q & ~ack_q & ~align_busy_q;
  reg  [1:0]     cause_q;
  localparam C_BOOT = 2'h0, C_FRAME = 2'h1, C_REQ = 2'h2;
  wire start = boot_q | frame_rise | req_new;

  // Buffer storage, pointers, and wrapping level.
  localparam AW = 3;
  reg  [W-1:0]   mem_i_q [0:DEPTH-1];
  reg  [W-1:0]   mem_q_q [0:DEPTH-1];
  reg  [AW-1:0]  wp_q;
  reg  [AW-1:0]  rp_q;
  reg  [DEPTH-1:0] vld_q;
  reg            rd_tick_q;
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      wp_q <= {AW{1'b0}};
      rp_q <= {AW{1'b0}};
      rd_tick_q <= 1'b0;
      align_busy_q <= 1'b0;
      cause_q <= C_BOOT;
      boot_q <= 1'b1;
      init_q <= 1'b0;
      framed_q <= 1'b0;
      ack_q <= 1'b0;
    end else if (ce) begin
      boot_q <= 1'b0;
      // The read side steps one cycle after each write tick, so the gap is kept.
      // With an offset of seven the level reads empty for that single cycle.
      rd_tick_q <= wr_tick;
      if (start) begin
        // Priority: chip reset, then frame, then serial request.
        rp_q <= {AW{1'b0}};
        wp_q <= ofs_q;
        align_busy_q <= 1'b1;
        cause_q <= boot_q ? C_BOOT : (frame_rise ? C_FRAME : C_REQ);
        if (frame_rise) framed_q <= 1'b0;
      end else begin
        if (wr_tick) wp_q <= wp_q + 1'b1;
        if (rd_tick_q) rp_q <= rp_q + 1'b1;
        if (align_busy_q && wr_tick) begin
          align_busy_q <= 1'b0;
          case (cause_q)
            C_BOOT:  init_q <= 1'b1;
            C_FRAME: framed_q <= 1'b1;
            C_REQ:   ack_q <= 1'b1;
            default: init_q <= init_q;
          endcase
        end
      end
      // The ack stays up while the request is held; clearing it drops the ack.
      if (!req_q && !(align_busy_q && wr_tick && cause_q == C_REQ)) ack_q <= 1'b0;
    end
  end

  genvar g;
  generate
    for (g = 0; g < DEPTH; g = g + 1) begin : g_ent
      wire [31:0]   gv = g;
      wire [AW-1:0] dw = gv[AW-1:0] - rp_q;
      wire [AW-1:0] dn = wp_q - rp_q;
      // Entry is valid when it lies from read up to write pointer, wrapping.
      always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
          mem_i_q[g] <= {W{1'b0}};
          mem_q_q[g] <= {W{1'b0}};
          vld_q[g] <= 1'b0;
        end else if (ce) begin
          vld_q[g] <= dw < dn;
          if (wr_tick && wp_q == gv[AW-1:0]) begin
            // Offset binary flips the sign bit to reach two's complement.
            mem_i_q[g] <= {di_s2_q[W-1] ^ sample_format_select, di_s2_q[W-2:0]};
            mem_q_q[g] <= {dq_s2_q[W-1] ^ sample_format_select, dq_s2_q[W-2:0]};
          end
        end
      end
    end
  endgenerate

  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rd_i_q <= {W{1'b0}};
      rd_q_q <= {W{1'b0}};
    end else if (ce && rd_tick_q) begin
      rd_i_q <= mem_i_q[rp_q];
      rd_q_q <= mem_q_q[rp_q];
    end
  end

  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      ofs_q <= `TFA_OFS_RST;
      req_q <= 1'b0;
      shg_q <= `TFA_GAIN_RST;
      i1g_q <= `TFA_GAIN_RST;
    end else if (ce && reg_wr) begin
      if (reg_addr == `TFA_ADDR_ALIGN) begin
        ofs_q <= reg_wdata[`TFA_OFS_HI:`TFA_OFS_LO];
        req_q <= reg_wdata[`TFA_BIT_REQ];
      end
      if (reg_addr == `TFA_ADDR_SHGAIN) shg_q <= reg_wdata[`TFA_GAIN_HI:`TFA_GAIN_LO];
      if (reg_addr == `TFA_ADDR_I1GAIN) i1g_q <= reg_wdata[`TFA_GAIN_HI:`TFA_GAIN_LO];
    end
  end

  always @* begin
    case (reg_addr)
      `TFA_ADDR_ALIGN:  reg_rdata = {1'b0, init_q, framed_q, ack_q, req_q, ofs_q};
      `TFA_ADDR_LEVEL:  reg_rdata = vld_q;
      `TFA_ADDR_SHGAIN: reg_rdata = {3'h0, shg_q};
      `TFA_ADDR_I1GAIN: reg_rdata = {3'h0, i1g_q};
      default:          reg_rdata = 8'h00;
    endcase
  end

  tfa_gain #(.W(W)) u_shape (
    .clk_sys (clk_sys),
    .resetn  (resetn),
    .ce      (ce),
    .gain    (shg_q),
    .in_i    (rd_i_q),
    .in_q    (rd_q_q),
    .out_i   (shaped_i),
    .out_q   (shaped_q)
  );
  tfa_gain #(.W(W)) u_int1 (
    .clk_sys (clk_sys),
    .resetn  (resetn),
    .ce      (ce),
    .gain    (i1g_q),
    .in_i    (shaped_i),
    .in_q    (shaped_q),
    .out_i   (interp_i),
    .out_q   (interp_q)
  );
endmodule
`default_nettype wire

// File: core/tfa_defs.vh
`ifndef TFA_DEFS_VH
`define TFA_DEFS_VH
// Register addresses on the serial-port register access.
`define TFA_ADDR_ALIGN   8'h33
`define TFA_ADDR_LEVEL   8'h34
`define TFA_ADDR_SHGAIN  8'h35
`define TFA_ADDR_I1GAIN  8'h36
// Alignment control bit positions.
`define TFA_BIT_INIT     6
`define TFA_BIT_FRAMED   5
`define TFA_BIT_ACK      4
`define TFA_BIT_REQ      3
`define TFA_OFS_HI       2
`define TFA_OFS_LO       0
// Reset values.
`define TFA_OFS_RST      3'h4
`define TFA_GAIN_RST     5'h10
// Gain codes are unsigned 1.4 values.
`define TFA_GAIN_FRAC    4
// Gain code field inside the two gain registers.
`define TFA_GAIN_HI      4
`define TFA_GAIN_LO      0
`endif

// File: core/tfa_gain.v
`timescale 1ns/1ps
`default_nettype none
module tfa_gain #(
  parameter W = 12
) (
  // Clock and control
  input  wire         clk_sys,
  input  wire         resetn,
  input  wire         ce,
  input  wire [4:0]   gain,
  // Samples
  input  wire [W-1:0] in_i,
  input  wire [W-1:0] in_q,
  output reg  [W-1:0] out_i,
  output reg  [W-1:0] out_q
);
`include "tfa_defs.vh"
  wire signed [W+5:0] pi;
  wire signed [W+5:0] pq;
  wire signed [W+5:0] si;
  wire signed [W+5:0] sq;
  wire signed [W-1:0] mx;
  wire signed [W-1:0] mn;
  assign pi = $signed(in_i) * $signed({1'b0, gain});
  assign pq = $signed(in_q) * $signed({1'b0, gain});
  assign si = pi >>> `TFA_GAIN_FRAC;
  assign sq = pq >>> `TFA_GAIN_FRAC;
  assign mx = {1'b0, {(W-1){1'b1}}};
  assign mn = {1'b1, {(W-1){1'b0}}};
  // Gains near two would wrap; saturating keeps the output on the right rail.
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      out_i <= {W{1'b0}};
      out_q <= {W{1'b0}};
    end else if (ce) begin
      out_i <= (si > mx) ? mx : (si < mn) ? mn : si[W-1:0];
      out_q <= (sq > mx) ? mx : (sq < mn) ? mn : sq[W-1:0];
    end
  end
endmodule
`default_nettype wire

// File: tb/tfa_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module tfa_monitor (
  // Clock and reset
  input wire logic        clk_sys,
  input wire logic        resetn,
  // Watched ports
  input wire logic        ce,
  input wire logic        reg_wr,
  input wire logic [7:0]  reg_addr,
  input wire logic [7:0]  reg_wdata,
  input wire logic [7:0]  reg_rdata,
  input wire logic [11:0] shaped_i,
  input wire logic [11:0] rd_i_q
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  wire logic a33 = reg_addr == 8'h33;
  wire logic g35 = reg_addr == 8'h35;
  wire logic g36 = reg_addr == 8'h36;
  wire logic w = ce && reg_wr;
  spare_bit_a: assert property (a33 |-> !reg_rdata[7])
    else $error("spare bit set");
  init_sticky_a: assert property (a33 && reg_rdata[6] |=> !a33 || reg_rdata[6])
    else $error("init flag dropped");
  gain_top_a: assert property (g35 || g36 |-> reg_rdata[7:5] == 3'h0)
    else $error("gain upper bits set");
  shape_gain_a: assert property (
    w && g35 |=> !g35 || reg_rdata[4:0] == $past(reg_wdata[4:0]))
    else $error("shaping gain lost");
  interp_gain_a: assert property (
    w && g36 |=> !g36 || reg_rdata[4:0] == $past(reg_wdata[4:0]))
    else $error("interp gain lost");
  offset_kept_a: assert property (
    w && a33 |=> !a33 || reg_rdata[3:0] == $past(reg_wdata[3:0]))
    else $error("offset or request lost");
  ack_drop_a: assert property (w && a33 && !reg_wdata[3] |-> ##2 (!a33 || !reg_rdata[4]))
    else $error("ack stayed");
  frozen_rd_a: assert property (!ce |=> $stable(rd_i_q))
    else $error("read data moved");
  frozen_gain_a: assert property (!ce |=> $stable(shaped_i))
    else $error("gain output moved");
  cover property (w && a33 && reg_wdata[3]);
  cover property (a33 && reg_rdata[5]);
  cover property (!ce);
endmodule
bind tfa_top tfa_monitor tfa_monitor_i (.clk_sys(clk_sys), .resetn(resetn), .ce(ce),
  .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .shaped_i(shaped_i), .rd_i_q(rd_i_q));
`default_nettype wire

// File: tb/tfa_bb_model.sv
`timescale 1ns/1ps
`default_nettype none
module tfa_bb_model (
  // Bench control
  input  wire logic        run,
  input  wire logic        go,
  input  wire logic [11:0] si,
  input  wire logic [11:0] sq,
  // Link pins
  output var  logic        lck,
  output var  logic        frm,
  output var  logic [11:0] ti,
  output var  logic [11:0] tq
);
  // Data change on the falling edge so they are settled at the rising one.
  initial begin
    {lck, frm, ti, tq} = '0;
    forever begin
      #40;
      if (run) lck = ~lck;
      if (!lck) {frm, ti, tq} = {go, si, sq};
    end
  end
endmodule
`default_nettype wire

// File: tb/tb_tfa_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_tfa_top;
  logic        clk, lck, frm, rst_n = 0, ce = 1, go = 0, run = 0, fmt = 0, wr_en = 0;
  logic [7:0]  addr = 0, wd = 0, rdat, v;
  logic [11:0] si = 0, sq = 0, ti, tq, sh_i, sh_q, it_i, it_q, rd_i, rd_q;
  int          err_total = 0, n_compared = 0, cyc = 0;
  tfa_bb_model tfa_bb_model_i (.run(run), .go(go), .si(si), .sq(sq), .lck(lck), .frm(frm),
    .ti(ti), .tq(tq));
  tfa_top tfa_top_i (.clk_sys(clk), .resetn(rst_n), .ce(ce), .interface_clock_pin(lck),
    .frame_in(frm), .tx_i(ti), .tx_q(tq), .sample_format_select(fmt), .reg_wr(wr_en),
    .reg_addr(addr), .reg_wdata(wd), .reg_rdata(rdat), .shaped_i(sh_i), .shaped_q(sh_q),
    .interp_i(it_i), .interp_q(it_q), .rd_i_q(rd_i), .rd_q_q(rd_q));
  initial begin
    clk = 0;
    forever #2 clk = ~clk;
  end
  task chk(input logic [11:0] g, e);
    n_compared++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task wr(input logic [7:0] a, d);
    @(posedge clk);
    #1 {wr_en, addr, wd} = {1'b1, a, d};
    @(posedge clk);
    #1 wr_en = 0;
  endtask
  task rd(input logic [7:0] a);
    @(posedge clk);
    #1 addr = a;
    #1 v = rdat;
  endtask
  task poll(input int b);
    rd(8'h33);
    for (int k = 0; k < 400 && v[b] !== 1'b1; k++) rd(8'h33);
    chk(v[b], 1);
  endtask
  task lvl(input int o);
    int n, t;
    @(negedge lck);
    repeat (3) @(posedge clk);
    rd(8'h34);
    n = 0;
    t = 0;
    for (int k = 0; k < 8; k++) begin
      n += v[k];
      t += v[k] != v[(k+1)%8];
    end
    chk(n, o);
    chk(t, o ? 2 : 0);
  endtask
  task t_req;
    int o;
    for (int j = 0; j < 3; j++) begin
      o = (7 * j) % 10;
      wr(8'h33, {5'h01, o[2:0]});
      poll(4);
      chk(v, {5'h0B, o[2:0]});
      lvl(o);
      wr(8'h33, {5'h00, o[2:0]});
      repeat (2) @(posedge clk);
      rd(8'h33);
      chk(v[4], 0);
    end
  endtask
  task t_path(input logic f, input logic [11:0] s, input logic [7:0] g0, g1,
              input logic [11:0] e0, e1);
    wr(8'h35, g0);
    wr(8'h36, g1);
    @(posedge clk);
    #1 {fmt, si, sq} = {f, s, 12'h100};
    repeat (150) @(posedge clk);
    #1;
    chk(rd_i, 12'h200);
    chk(sh_i, e0);
    chk(it_i, e1);
  endtask
  task results;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      err_total++;
      results;
    end
  end
  initial begin
    repeat (12) @(posedge clk);
    #1 {rst_n, run} = 2'b11;
    poll(6);
    chk(v, 8'h44);
    rd(8'h35);
    chk(v, 8'h10);
    rd(8'h36);
    chk(v, 8'h10);
    t_req;
    @(posedge clk);
    #1 go = 1;
    poll(5);
    @(posedge clk);
    #1 go = 0;
    // The level register is read-only, so this write must leave it alone.
    wr(8'h34, 8'hFF);
    lvl(4);
    rd(8'h40);
    chk(v, 0);
    t_path(0, 12'h200, 8'h08, 8'h10, 12'h100, 12'h100);
    chk(sh_q, 12'h080);
    chk(rd_q, 12'h100);
    chk(it_q, 12'h080);
    t_path(1, 12'hA00, 8'h1F, 8'h00, 12'h3E0, 12'h000);
    chk(rd_q, 12'h900);
    chk(sh_q, 12'h800);
    chk(it_q, 12'h000);
    @(posedge clk);
    #1 ce = 0;
    repeat (3) @(posedge clk);
    #1 ce = 1;
    results;
  end
endmodule
`default_nettype wire
